/* File: design/tcm_pkg.sv */
// package: register map, field layout, encodings for the 8-bit timer compare block
package tcm_pkg;

    // =====================================================================
    // register byte offsets (APB, one word each)
    localparam logic [7:0] OFF_CTRL_A  = 8'h00;
    localparam logic [7:0] OFF_CTRL_C  = 8'h04;
    localparam logic [7:0] OFF_COUNT   = 8'h08;
    localparam logic [7:0] OFF_CMP_A   = 8'h0C;
    localparam logic [7:0] OFF_CMP_B   = 8'h10;
    localparam logic [7:0] OFF_FLAGS   = 8'h14;
    localparam logic [7:0] OFF_PORT    = 8'h18;
    localparam logic [7:0] OFF_STATUS  = 8'h1C;

    // =====================================================================
    // field positions
    localparam int FLG_OVF     = 0;
    localparam int FLG_MATCH_A = 1;
    localparam int FLG_MATCH_B = 2;
    localparam int PORT_DIR_LSB = 2;

    // =====================================================================
    // reset values
    localparam logic [9:0] CTRL_RST  = 10'h000;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST   = 8'h00;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [1:0] OUT_RST   = 2'h0;
    localparam logic [7:0] COUNT_MAX = 8'hFF;

    // =====================================================================
    // encodings
    localparam logic [2:0] WAVE_NORMAL = 3'h0;
    localparam logic [2:0] WAVE_CTC    = 3'h2;

    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV64   = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam int PRE_W = 10;

    typedef enum logic [1:0] {
        ACT_KEEP   = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_CLEAR  = 2'b10,
        ACT_SET    = 2'b11
    } tcm_action_t;

    typedef enum logic {
        APB_WAIT = 1'b0,
        APB_DONE = 1'b1
    } tcm_apb_state_t;

    // control word, bit 0 at the bottom
    typedef struct packed {
        logic [2:0] clockSelect;
        logic [2:0] waveformSelect;
        logic [1:0] actionB;
        logic [1:0] actionA;
    } tcm_ctrl_t;

endpackage : tcm_pkg

/* File: design/tcm_timer8_compare.sv */
// 8-bit timer/counter with compare-match outputs, APB register slave
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module tcm_timer8_compare
    import tcm_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // port pins, bit 0 unit A, bit 1 unit B
    output logic      [1:0]  pinOut,
    output logic      [1:0]  pinOe
);

    // =====================================================================
    // state
    tcm_ctrl_t      ctrl;
    tcm_apb_state_t apbState;
    logic [7:0]     countValue;
    logic [7:0]     compareValueA;
    logic [7:0]     compareValueB;
    logic [2:0]     flags;
    logic [1:0]     portValue;
    logic [1:0]     portDir;
    logic [1:0]     compareOut;
    logic           blockMatch;
    logic [PRE_W-1:0] prescale;

    // =====================================================================
    // helpers
    function automatic logic tickFor(input logic [2:0] sel,
                                     input logic [PRE_W-1:0] pre);
        case (sel)
            CS_DIV1:    tickFor = 1'b1;
            CS_DIV8:    tickFor = &pre[2:0];
            CS_DIV64:   tickFor = &pre[5:0];
            CS_DIV256:  tickFor = &pre[7:0];
            CS_DIV1024: tickFor = &pre[9:0];
            default:    tickFor = 1'b0;
        endcase
    endfunction : tickFor

    // set, clear or toggle as the action field asks
    function automatic logic applyAction(input logic [1:0] act, input logic cur);
        unique case (tcm_action_t'(act))
            ACT_KEEP:   applyAction = cur;
            ACT_TOGGLE: applyAction = ~cur;
            ACT_CLEAR:  applyAction = 1'b0;
            ACT_SET:    applyAction = 1'b1;
        endcase
    endfunction : applyAction

    // =====================================================================
    // decode
    logic       wrEn;
    logic       countWrite;
    logic       timerTickEnable;
    logic       nonPwm;
    logic       matchA;
    logic       matchB;
    logic [1:0] forceStrobe;
    logic [1:0] action [2];
    logic [2:0] flagSet;
    logic [2:0] flagClr;

    // writes land on the completing access edge only
    assign wrEn            = clkEn && psel && penable && pready && pwrite;
    assign countWrite      = wrEn && (paddr == OFF_COUNT);
    assign timerTickEnable = clkEn && tickFor(ctrl.clockSelect, prescale);
    assign nonPwm          = (ctrl.waveformSelect == WAVE_NORMAL) ||
                             (ctrl.waveformSelect == WAVE_CTC);
    // a match seen while the block is armed is dropped
    assign matchA = (countValue == compareValueA) && !blockMatch;
    assign matchB = (countValue == compareValueB) && !blockMatch;
    assign forceStrobe = (wrEn && paddr == OFF_CTRL_C && nonPwm) ? pwdata[1:0] : 2'b00;
    assign action[0] = ctrl.actionA;
    assign action[1] = ctrl.actionB;

    assign flagSet[FLG_OVF] = timerTickEnable && !countWrite && nonPwm &&
                              (countValue == COUNT_MAX);
    assign flagSet[FLG_MATCH_A] = timerTickEnable && matchA;
    assign flagSet[FLG_MATCH_B] = timerTickEnable && matchB;
    assign flagClr = (wrEn && paddr == OFF_FLAGS) ? pwdata[2:0] : 3'h0;

    // =====================================================================
    // prescaler, free running; stop selection gives no tick
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prescale <= '0;
        end else if (clkEn) begin
            prescale <= prescale + 1'b1;
        end
    end

    // =====================================================================
    // control registers; action field takes effect with no buffering
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl          <= tcm_ctrl_t'(CTRL_RST);
            compareValueA <= CMP_RST;
            compareValueB <= CMP_RST;
            portValue     <= 2'h0;
            portDir       <= 2'h0;
        end else if (wrEn) begin
            case (paddr)
                OFF_CTRL_A: ctrl          <= tcm_ctrl_t'(pwdata[9:0]);
                OFF_CMP_A:  compareValueA <= pwdata[7:0];
                OFF_CMP_B:  compareValueB <= pwdata[7:0];
                OFF_PORT: begin
                    portValue <= pwdata[1:0];
                    portDir   <= pwdata[PORT_DIR_LSB+1:PORT_DIR_LSB];
                end
                default: ;
            endcase
        end
    end

    // =====================================================================
    // counter: software write wins over count and clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            countValue <= COUNT_RST;
        end else if (countWrite) begin
            countValue <= pwdata[7:0];
        end else if (timerTickEnable) begin
            // a lower top just misses and the count runs through 0xFF
            if (ctrl.waveformSelect == WAVE_CTC && matchA) begin
                countValue <= COUNT_RST;
            end else begin
                countValue <= countValue + 8'h01;
            end
        end
    end

    // armed by a count write, released by the next tick
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            blockMatch <= 1'b0;
        end else if (countWrite) begin
            blockMatch <= 1'b1;
        end else if (timerTickEnable) begin
            blockMatch <= 1'b0;
        end
    end

    // =====================================================================
    // flags: set beats a same-cycle write-one clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags <= FLAGS_RST;
        end else if (clkEn) begin
            flags <= (flags & ~flagClr) | flagSet;
        end
    end

    // =====================================================================
    // output-compare state; untouched by mode changes, PWM shaping not built
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            compareOut <= OUT_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (forceStrobe[i]) begin
                    compareOut[i] <= applyAction(action[i], compareOut[i]);
                end else if (timerTickEnable && nonPwm &&
                             (i == 0 ? matchA : matchB)) begin
                    compareOut[i] <= applyAction(action[i], compareOut[i]);
                end
            end
        end
    end

    // =====================================================================
    // pins: override chosen by action field alone, direction from port
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinOut <= 2'h0;
            pinOe  <= 2'h0;
        end else if (clkEn) begin
            for (int i = 0; i < 2; i++) begin
                pinOut[i] <= (action[i] != ACT_KEEP) ? compareOut[i] : portValue[i];
            end
            pinOe <= portDir;
        end
    end

    // =====================================================================
    // apb: one wait state so that read data comes from a flop
    logic [31:0] rdData;
    logic        rdHit;

    always_comb begin
        rdHit  = 1'b1;
        rdData = 32'h0;
        case (paddr)
            OFF_CTRL_A: rdData = 32'(ctrl);
            OFF_CTRL_C: rdData = 32'h0;
            OFF_COUNT:  rdData = 32'(countValue);
            OFF_CMP_A:  rdData = 32'(compareValueA);
            OFF_CMP_B:  rdData = 32'(compareValueB);
            OFF_FLAGS:  rdData = 32'(flags);
            OFF_PORT:   rdData = 32'({portDir, portValue});
            OFF_STATUS: rdData = 32'(compareOut);
            default:    rdHit  = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            apbState <= APB_WAIT;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0;
        end else if (clkEn) begin
            unique case (apbState)
                APB_WAIT: begin
                    if (psel && penable) begin
                        apbState <= APB_DONE;
                        pready   <= 1'b1;
                        pslverr  <= !rdHit;
                        prdata   <= pwrite ? 32'h0 : rdData;
                    end
                end
                APB_DONE: begin
                    apbState <= APB_WAIT;
                    pready   <= 1'b0;
                    pslverr  <= 1'b0;
                end
            endcase
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_BLOCK_AFTER_WRITE: assert property (
        blockMatch && timerTickEnable && !wrEn |=> compareOut == $past(compareOut) &&
            flags[FLG_MATCH_A] == $past(flags[FLG_MATCH_A]))
        else $error("match not blocked after count write");

    AST_MODE_KEEPS_OUT: assert property (
        wrEn && paddr == OFF_CTRL_A && !timerTickEnable |=> compareOut == $past(compareOut))
        else $error("output state changed on mode write");

    AST_RESET_CLEARS: assert property (disable iff (1'b0)
        sys_rst |=> compareOut == 2'b00 && pinOut == 2'b00)
        else $error("reset left output state set");

    AST_PIN_SOURCE: assert property (
        clkEn |=> pinOut[0] == ($past(ctrl.actionA) != ACT_KEEP ?
            $past(compareOut[0]) : $past(portValue[0])) && pinOe == $past(portDir))
        else $error("pin source wrong");

    AST_KEEP_ACTION: assert property (
        timerTickEnable && ctrl.actionA == ACT_KEEP |=> compareOut[0] == $past(compareOut[0]))
        else $error("keep action changed output");

    AST_FORCE_ONLY_OUT: assert property (
        forceStrobe[0] && ctrl.actionA == ACT_TOGGLE && !timerTickEnable |=>
            compareOut[0] != $past(compareOut[0]) && flags == $past(flags) &&
            countValue == $past(countValue))
        else $error("force misbehaved");

    AST_NORMAL_INC: assert property (
        timerTickEnable && !countWrite && ctrl.waveformSelect == WAVE_NORMAL |=>
            countValue == $past(countValue) + 8'h01)
        else $error("normal mode did not increment");

    AST_OVF_ON_WRAP: assert property (
        timerTickEnable && !countWrite && nonPwm && countValue == COUNT_MAX |=>
            flags[FLG_OVF] && countValue == 8'h00)
        else $error("overflow not set on wrap");

    AST_CTC_CLEAR: assert property (
        timerTickEnable && !countWrite && ctrl.waveformSelect == WAVE_CTC && matchA |=>
            countValue == 8'h00 && flags[FLG_MATCH_A])
        else $error("clear-on-match failed");

    AST_FLAG_B: assert property (
        timerTickEnable && matchB |=> flags[FLG_MATCH_B])
        else $error("match flag b not set");

    AST_TICK_ONLY: assert property (
        !timerTickEnable && !wrEn |=> countValue == $past(countValue) &&
            compareOut == $past(compareOut))
        else $error("state moved without tick");

    AST_APB_ANSWER: assert property (
        clkEn && psel && penable && !pready |=> pready)
        else $error("apb answer late");

    AST_APB_ONE_CYCLE: assert property (
        clkEn && pready |=> !pready)
        else $error("apb answer held too long");

    AST_PIN_SOURCE_B: assert property (
        clkEn |=> pinOut[1] == ($past(ctrl.actionB) != ACT_KEEP ?
            $past(compareOut[1]) : $past(portValue[1])))
        else $error("pin b source wrong");

    // hardware may only set flags; a one drops only through a clear write
    AST_FLAG_ONLY_SET: assert property (
        clkEn && !(wrEn && paddr == OFF_FLAGS) |=> (flags & $past(flags)) == $past(flags))
        else $error("flag cleared without a write");

    AST_COUNT_WRITE: assert property (
        countWrite |=> countValue == $past(pwdata[7:0]))
        else $error("count write lost");

    AST_PWM_NO_ACTION: assert property (
        timerTickEnable && !nonPwm |=> compareOut == $past(compareOut))
        else $error("output state moved in pwm mode");

endmodule : tcm_timer8_compare

/* File: test/tcm_timer8_compare_tb_top.sv */
// self-checking bench for the 8-bit timer compare block
`timescale 1ns/1ps
module tcm_timer8_compare_tb_top;
    import tcm_pkg::*;
    // =====================================================================
    // stimulus and observed signals
    logic        clk     = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clkEn   = 1'b1;
    logic [7:0]  paddr   = 8'h00;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  pinOut;
    logic [1:0]  pinOe;
    int          n_fail  = 0;
    int          checked = 0;
    int          cycles  = 0;

    always #4 clk = ~clk;

    tcm_timer8_compare u_dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinOut(pinOut), .pinOe(pinOe));

    // =====================================================================
    // helpers
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask : rd

    function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [2:0] wv,
                                        input logic [1:0] ab, input logic [1:0] aa);
        tcm_ctrl_t c;
        c = '{clockSelect: cs, waveformSelect: wv, actionB: ab, actionA: aa};
        return {22'h0, c};
    endfunction : ctl

    function automatic logic act(input logic s, input logic [1:0] a);
        case (a)
            ACT_KEEP:   return s;
            ACT_TOGGLE: return ~s;
            ACT_CLEAR:  return 1'b0;
            default:    return 1'b1;
        endcase
    endfunction : act

    function automatic int pre(input int cs);
        case (cs)
            1:       return 1;
            2:       return 8;
            3:       return 64;
            4:       return 256;
            default: return 1024;
        endcase
    endfunction : pre

    // cycles between two pin-A edges; the first two intervals may straddle the select change
    task automatic halfPeriod(output int p);
        int   n;
        logic v;
        @(posedge clk);
        for (int k = 0; k < 3; k++) begin
            n = 0;
            v = pinOut[0];
            do begin
                @(posedge clk);
                n++;
            end while (pinOut[0] === v && n < 20000);
        end
        p = n;
    endtask : halfPeriod

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // hang guard: the sequence needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // =====================================================================
    // main sequence
    logic [31:0] q;
    logic [31:0] q2;
    logic        e;
    logic [1:0]  st;
    logic [1:0]  port;
    logic [1:0]  aa;
    logic [1:0]  ab;
    logic [1:0]  f;
    logic [7:0]  tv [3] = '{8'h05, 8'h04, 8'hFD};
    logic [2:0]  tf [3] = '{3'h0, 3'h4, 3'h1};
    logic [7:0]  c;
    int          p;
    int          moved;

    initial begin
        void'($urandom(93110));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, q, e);
            chk("reset read", {q[30:0], e}, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        chk("pins at reset", {pinOe, pinOut}, 32'h0);
        // forced compares, every action on unit A
        port = 2'($urandom);
        wr(OFF_CTRL_A, ctl(CS_STOP, WAVE_NORMAL, ACT_CLEAR, ACT_CLEAR));
        wr(OFF_CTRL_C, 32'h3);
        wr(OFF_PORT, {28'h0, 2'b11, port});
        st = 2'b00;
        for (int i = 0; i < 8; i++) begin
            aa = 2'(i);
            ab = 2'($urandom);
            f = 2'(1 + $urandom % 3);
            wr(OFF_CTRL_A, ctl(CS_STOP, WAVE_NORMAL, ab, aa));
            wr(OFF_CTRL_C, {30'h0, f});
            if (f[0]) st[0] = act(st[0], aa);
            if (f[1]) st[1] = act(st[1], ab);
            rd(OFF_STATUS, q);
            chk("output state", q, {30'h0, st});
            rd(OFF_FLAGS, q);
            chk("flags after force", q, 32'h0);
            chk("pin value", pinOut, {ab != 2'b00 ? st[1] : port[1], aa != 2'b00 ? st[0] : port[0]});
            chk("pin enable", pinOe, 32'h3);
        end
        rd(OFF_COUNT, q);
        chk("count after force", q, 32'h0);
        wr(OFF_CTRL_A, ctl(CS_STOP, WAVE_CTC, ab, aa));
        rd(OFF_STATUS, q);
        chk("state across mode change", q, {30'h0, st});
        chk("pin across mode change", pinOut, {ab != 2'b00 ? st[1] : port[1], st[0]});
        // count write blocks the next match; wrap in normal mode
        wr(OFF_CMP_A, 32'h80);
        wr(OFF_CMP_B, 32'h05);
        for (int k = 0; k < 3; k++) begin
            wr(OFF_CTRL_A, ctl(CS_STOP, WAVE_NORMAL, 2'b00, 2'b00));
            // actions are zero here, so a count equal to compare B spoils no waveform
            wr(OFF_COUNT, {24'h0, tv[k]});
            wr(OFF_FLAGS, 32'h7);
            wr(OFF_CTRL_A, ctl(CS_DIV1, WAVE_NORMAL, 2'b00, 2'b00));
            wr(OFF_CTRL_A, ctl(CS_STOP, WAVE_NORMAL, 2'b00, 2'b00));
            rd(OFF_FLAGS, q);
            chk("flags after short run", q, {29'h0, tf[k]});
        end
        rd(OFF_COUNT, q);
        chk("count wrapped", {31'h0, q < 32'h8}, 32'h1);
        // top below count: runs through 0xFF first
        wr(OFF_CMP_A, 32'h10);
        wr(OFF_CMP_B, 32'hFF);
        wr(OFF_COUNT, 32'h80);
        wr(OFF_FLAGS, 32'h7);
        wr(OFF_CTRL_A, ctl(CS_DIV1, WAVE_CTC, 2'b00, 2'b00));
        repeat (100) @(posedge clk);
        rd(OFF_FLAGS, q);
        chk("flags before wrap", q, 32'h0);
        repeat (100) @(posedge clk);
        rd(OFF_FLAGS, q);
        chk("flags after wrap", q, 32'h7);
        rd(OFF_COUNT, q);
        chk("count under top", {31'h0, q <= 32'h10}, 32'h1);
        // toggle rate for every prescale
        c = 8'($urandom % 4);
        wr(OFF_CMP_A, {24'h0, c});
        wr(OFF_COUNT, 32'h0);
        for (int cs = 1; cs <= 5; cs++) begin
            wr(OFF_CTRL_A, ctl(3'(cs), WAVE_CTC, 2'b00, ACT_TOGGLE));
            halfPeriod(p);
            chk("toggle half period", p, pre(cs) * (1 + c));
        end
        // enable low freezes everything
        wr(OFF_CTRL_A, ctl(CS_DIV1, WAVE_CTC, 2'b00, ACT_TOGGLE));
        clkEn <= 1'b0;
        @(posedge clk);
        q[1:0] = pinOut;
        moved = 0;
        repeat (40) begin
            @(posedge clk);
            if (pinOut !== q[1:0]) moved++;
        end
        clkEn <= 1'b1;
        chk("changes while disabled", moved, 32'h0);
        // action zero: pin source back to port, state kept
        wr(OFF_CTRL_A, ctl(CS_DIV1, WAVE_CTC, 2'b00, ACT_KEEP));
        rd(OFF_STATUS, q);
        chk("pin source after action write", pinOut[0], port[0]);
        repeat (50) @(posedge clk);
        rd(OFF_STATUS, q2);
        chk("state under keep", q2, q);
        // waveform code 1 is a pwm mode: no force, no match action, pin source from action field
        wr(OFF_CTRL_A, ctl(CS_DIV1, 3'h1, ACT_TOGGLE, ACT_TOGGLE));
        rd(OFF_STATUS, q);
        wr(OFF_CTRL_C, 32'h3);
        rd(OFF_STATUS, q2);
        chk("state in pwm mode", q2, q);
        chk("pin source in pwm mode", pinOut, q[1:0]);
        // reset in mid-run clears set state
        wr(OFF_CTRL_A, ctl(CS_STOP, WAVE_NORMAL, ACT_SET, ACT_SET));
        wr(OFF_CTRL_C, 32'h3);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(OFF_STATUS, q);
        chk("state after reset", q, 32'h0);
        tally_and_finish();
    end

endmodule : tcm_timer8_compare_tb_top
